// >>> logic/ramb_pkg.sv
package ramb_pkg;

  // ==========================================================
  // Array geometry
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int BYTES = 4;
  localparam int ADDR_W = 7;
  localparam int LANE_W = 6;
  localparam logic [DATA_W-1:0] UNKNOWN_FILL = 36'h000000000;

  // ==========================================================
  // Register map
  localparam int APB_AW = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_KIND_LSB = 3;
  localparam int CTRL_OREG_A = 5;
  localparam int CTRL_OREG_B = 6;
  localparam int CTRL_FLOW = 7;
  localparam int CTRL_RDW_OLD = 8;
  localparam int CTRL_WA_LSB = 9;
  localparam int CTRL_WB_LSB = 12;
  localparam logic [31:0] CTRL_WMASK = 32'h00007fff;
  localparam logic [31:0] CTRL_RESET = 32'h00005b68;
  localparam int ST_COLL = 0;
  localparam int ST_LANE_A = 1;
  localparam int ST_LANE_B = 2;

  // ==========================================================
  // Modes and kinds
  typedef enum logic [2:0] {
    MODE_TRUE_DUAL = 3'b000,
    MODE_SIMPLE_DUAL = 3'b001,
    MODE_SINGLE = 3'b010,
    MODE_SPLIT = 3'b011,
    MODE_ROM = 3'b100
  } ramb_mode_t;

  typedef enum logic [1:0] {
    KIND_SMALL = 2'b00,
    KIND_MEDIUM = 2'b01,
    KIND_LARGE = 2'b10
  } ramb_kind_t;

  // Width codes: 1, 2, 4, 9, 18, 36 bits; all divide the word
  localparam logic [2:0] WCODE_1 = 3'h0;
  localparam logic [2:0] WCODE_2 = 3'h1;
  localparam logic [2:0] WCODE_4 = 3'h2;
  localparam logic [2:0] WCODE_9 = 3'h3;
  localparam logic [2:0] WCODE_18 = 3'h4;
  localparam logic [2:0] WCODE_36 = 3'h5;

  // ==========================================================
  // Port request carrier
  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [LANE_W-1:0] lane;
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0] be;
  } ramb_req_t;

endpackage : ramb_pkg

// >>> logic/ramb_port_reg.sv
`timescale 1ns/1ps
`default_nettype none

module ramb_port_reg #(
  parameter bit NEG = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire ramb_pkg::ramb_req_t d,
  output var ramb_pkg::ramb_req_t q
);
  import ramb_pkg::*;

  // ==========================================================
  // Input capture, rising or falling edge
  generate
    if (NEG) begin : g_neg
      always_ff @(negedge clk) begin
        if (rst) begin
          q <= '0;
        end else if (ce) begin
          q <= clr ? '0 : d;
        end
      end
    end else begin : g_pos
      always_ff @(posedge clk) begin
        if (rst) begin
          q <= '0;
        end else if (ce) begin
          q <= clr ? '0 : d;
        end
      end
    end
  endgenerate

endmodule : ramb_port_reg

`default_nettype wire

// >>> logic/ramb_mem.sv
`timescale 1ns/1ps
`default_nettype none

module ramb_mem #(
  parameter int DW = ramb_pkg::DATA_W,
  parameter int AW = ramb_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic wr0_en,
  input wire logic [AW-1:0] wr0_addr,
  input wire logic [DW-1:0] wr0_data,
  input wire logic [DW-1:0] wr0_mask,
  input wire logic wr1_en,
  input wire logic [AW-1:0] wr1_addr,
  input wire logic [DW-1:0] wr1_data,
  input wire logic [DW-1:0] wr1_mask,
  input wire logic [AW-1:0] rd0_addr,
  output logic [DW-1:0] rd0_data,
  input wire logic [AW-1:0] rd1_addr,
  output logic [DW-1:0] rd1_data
);
  import ramb_pkg::*;

  logic [DW-1:0] mem [2**AW];

  // ==========================================================
  // Masked writes; port 0 wins overlapping bits
  always_ff @(posedge clk) begin
    if (wr0_en && wr1_en && wr0_addr == wr1_addr) begin
      mem[wr0_addr] <= (mem[wr0_addr] & ~(wr0_mask | wr1_mask)) |
                       (wr1_data & wr1_mask & ~wr0_mask) | (wr0_data & wr0_mask);
    end else begin
      if (wr0_en) begin
        mem[wr0_addr] <= (mem[wr0_addr] & ~wr0_mask) | (wr0_data & wr0_mask);
      end
      if (wr1_en) begin
        mem[wr1_addr] <= (mem[wr1_addr] & ~wr1_mask) | (wr1_data & wr1_mask);
      end
    end
  end

  // Addresses arrive already registered, so this is still a sync RAM
  assign rd0_data = mem[rd0_addr];
  assign rd1_data = mem[rd1_addr];

endmodule : ramb_mem

`default_nettype wire

// >>> logic/ramb_top.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE1] Medium and large blocks run two ports, any mix of reads and writes
// [RULE2] Simple dual-port read with a write returns old data or fill bits
// [RULE3] Single-port writes show on output directly, or one edge later if registered; in split mode code loads port b's output register only on reads
// [RULE4] Write strobe is generated internally from the captured request
// [RULE5] All inputs pass through input registers; output registers are offered
// [RULE6] Output registers can be bypassed, giving combinational read data
// [RULE7] Small and medium flow-through reads capture read request on falling edge; code does this only for port b in simple dual-port mode
// [RULE8] Dual-port configurations allow a different data width on each port
// [RULE9] Medium block may host two single-port memories, each in one half
// [RULE10] Each byte carries a ninth bit, free for parity or user bits
// [RULE11] Medium and large blocks mask written bytes by per-byte enables
// [RULE12] Small and medium clears hit input and output registers; large only outputs
// [RULE13] Large block used as ROM is written once, then writes stay off
// [RULE14] Deeper memories need outside address decode and output selection
// [RULE15] Narrow lane zero maps to the least significant bits of the word
// [RULE16] Ninth bits are stored and returned unchanged, never generated or checked
module ramb_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ramb_pkg::ramb_req_t req_a,
  input wire logic clr_a,
  output logic [35:0] q_a,
  input wire ramb_pkg::ramb_req_t req_b,
  input wire logic clr_b,
  output logic [35:0] q_b
);
  import ramb_pkg::*;

  // ==========================================================
  // Helpers for lane placement
  function automatic int width_of(input logic [2:0] code);
    case (code)
      WCODE_1: width_of = 1;
      WCODE_2: width_of = 2;
      WCODE_4: width_of = 4;
      WCODE_9: width_of = 9;
      WCODE_18: width_of = 18;
      default: width_of = 36;
    endcase
  endfunction : width_of

  function automatic logic lane_ok(input logic [2:0] code, input logic [LANE_W-1:0] lane);
    lane_ok = (int'(lane) + 1) * width_of(code) <= DATA_W;
  endfunction : lane_ok

  function automatic logic [DATA_W-1:0] low_mask(input logic [2:0] code);
    low_mask = {DATA_W{1'b1}} >> (DATA_W - width_of(code));
  endfunction : low_mask

  function automatic logic [DATA_W-1:0] field_mask(input logic [2:0] code,
                                                   input logic [LANE_W-1:0] lane);
    field_mask = low_mask(code) << (int'(lane) * width_of(code));
  endfunction : field_mask

  function automatic logic [DATA_W-1:0] be_mask(input logic [BYTES-1:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BYTES; i++) begin
      m[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
    end
    be_mask = m;
  endfunction : be_mask

  // ==========================================================
  // Configuration and status registers
  logic [31:0] ctrl;
  logic [2:0] status;
  logic apb_acc;
  logic hit_ctrl;
  logic hit_status;
  ramb_mode_t mode;
  ramb_kind_t kind;
  logic oreg_a;
  logic oreg_b;
  logic flow_cfg;
  logic rdw_old;
  logic [2:0] wcode_a;
  logic [2:0] wcode_b;

  assign mode = ramb_mode_t'(ctrl[CTRL_MODE_LSB +: 3]);
  assign kind = ramb_kind_t'(ctrl[CTRL_KIND_LSB +: 2]);
  assign oreg_a = ctrl[CTRL_OREG_A];
  assign oreg_b = ctrl[CTRL_OREG_B];
  assign flow_cfg = ctrl[CTRL_FLOW];
  assign rdw_old = ctrl[CTRL_RDW_OLD];
  assign wcode_a = ctrl[CTRL_WA_LSB +: 3];
  assign wcode_b = ctrl[CTRL_WB_LSB +: 3]; // [RULE8]

  // Low clock enable stalls the bus too, so nothing is lost
  assign pready = ce;
  assign apb_acc = psel & penable & ce;
  assign hit_ctrl = paddr == CTRL_OFF;
  assign hit_status = paddr == STATUS_OFF;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_status);

  always_comb begin
    prdata = 32'h00000000;
    if (hit_ctrl) begin
      prdata = ctrl;
    end else if (hit_status) begin
      prdata = {29'h0000000, status};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (apb_acc && pwrite && hit_ctrl) begin
      ctrl <= pwdata & CTRL_WMASK;
    end
  end

  // ==========================================================
  // Input registers
  ramb_req_t req_a_q;
  ramb_req_t req_b_q;
  ramb_req_t req_b_n;
  ramb_req_t req_b_rd;
  logic clr_in_a;
  logic clr_in_b;
  logic flow_on;

  assign clr_in_a = clr_a & (kind != KIND_LARGE); // [RULE12]
  assign clr_in_b = clr_b & (kind != KIND_LARGE); // [RULE12]

  ramb_port_reg #(.NEG(1'b0)) u_reg_a (
    .clk(clk), .rst(rst), .ce(ce), .clr(clr_in_a), .d(req_a), .q(req_a_q)
  ); // [RULE5]

  ramb_port_reg #(.NEG(1'b0)) u_reg_b (
    .clk(clk), .rst(rst), .ce(ce), .clr(clr_in_b), .d(req_b), .q(req_b_q)
  ); // [RULE5]

  // Half-cycle read path; costs half a period of address setup
  ramb_port_reg #(.NEG(1'b1)) u_reg_bn (
    .clk(clk), .rst(rst), .ce(ce), .clr(clr_in_b), .d(req_b), .q(req_b_n)
  ); // [RULE7]

  assign flow_on = flow_cfg & (mode == MODE_SIMPLE_DUAL) & (kind != KIND_LARGE); // [RULE7]
  assign req_b_rd = flow_on ? req_b_n : req_b_q; // [RULE7]

  // ==========================================================
  // Port permissions and addressing
  logic can_wr_a;
  logic can_rd_a;
  logic can_wr_b;
  logic can_rd_b;
  logic split;
  logic [ADDR_W-1:0] word_a;
  logic [ADDR_W-1:0] word_b_wr;
  logic [ADDR_W-1:0] word_b_rd;
  logic ok_a;
  logic ok_b_wr;
  logic ok_b_rd;

  assign split = (mode == MODE_SPLIT) & (kind == KIND_MEDIUM); // [RULE9]
  assign can_wr_a = mode != MODE_ROM;
  assign can_rd_a = mode != MODE_SIMPLE_DUAL;
  assign can_wr_b = ((mode == MODE_TRUE_DUAL) & (kind != KIND_SMALL)) | split; // [RULE1]
  assign can_rd_b = (mode != MODE_SINGLE) & ((mode != MODE_SPLIT) | split);

  assign word_a = split ? {1'b0, req_a_q.addr[ADDR_W-2:0]} : req_a_q.addr; // [RULE9]
  assign word_b_wr = split ? {1'b1, req_b_q.addr[ADDR_W-2:0]} : req_b_q.addr; // [RULE9]
  assign word_b_rd = split ? {1'b1, req_b_rd.addr[ADDR_W-2:0]} : req_b_rd.addr;
  assign ok_a = lane_ok(wcode_a, req_a_q.lane);
  assign ok_b_wr = lane_ok(wcode_b, req_b_q.lane);
  assign ok_b_rd = lane_ok(wcode_b, req_b_rd.lane);

  // ==========================================================
  // Self-timed write strobes and masks
  logic wstb_a;
  logic wstb_b;
  logic [BYTES-1:0] wbe_a;
  logic [BYTES-1:0] wbe_b;
  logic [DATA_W-1:0] wmask_a;
  logic [DATA_W-1:0] wmask_b;
  logic [DATA_W-1:0] wdata_a;
  logic [DATA_W-1:0] wdata_b;

  // One strobe per captured request; fabric never shapes a pulse
  assign wstb_a = ce & req_a_q.we & can_wr_a & ok_a; // [RULE4]
  assign wstb_b = ce & req_b_q.we & can_wr_b & ok_b_wr; // [RULE4]
  assign wbe_a = (kind == KIND_SMALL) ? {BYTES{1'b1}} : req_a_q.be; // [RULE11]
  assign wbe_b = (kind == KIND_SMALL) ? {BYTES{1'b1}} : req_b_q.be; // [RULE11]
  assign wmask_a = field_mask(wcode_a, req_a_q.lane) & be_mask(wbe_a); // [RULE11] [RULE15]
  assign wmask_b = field_mask(wcode_b, req_b_q.lane) & be_mask(wbe_b); // [RULE11] [RULE15]
  // Ninth bits ride along like any data bit
  assign wdata_a = (req_a_q.data & low_mask(wcode_a)) << (int'(req_a_q.lane) * width_of(wcode_a)); // [RULE16]
  assign wdata_b = (req_b_q.data & low_mask(wcode_b)) << (int'(req_b_q.lane) * width_of(wcode_b)); // [RULE10]

  // ==========================================================
  // Array
  logic [DATA_W-1:0] arr_a;
  logic [DATA_W-1:0] arr_b;

  ramb_mem #(.DW(DATA_W), .AW(ADDR_W)) u_mem (
    .clk(clk),
    .wr0_en(wstb_a),
    .wr0_addr(word_a),
    .wr0_data(wdata_a),
    .wr0_mask(wmask_a),
    .wr1_en(wstb_b),
    .wr1_addr(word_b_wr),
    .wr1_data(wdata_b),
    .wr1_mask(wmask_b),
    .rd0_addr(word_a),
    .rd0_data(arr_a),
    .rd1_addr(word_b_rd),
    .rd1_data(arr_b)
  );

  // ==========================================================
  // Read path and output registers
  logic coll_a;
  logic coll_b;
  logic rden_a;
  logic rden_b;
  logic [DATA_W-1:0] rd_a;
  logic [DATA_W-1:0] rd_b;
  logic [DATA_W-1:0] q_reg_a;
  logic [DATA_W-1:0] q_reg_b;

  // Array still holds old data while the other port's strobe is up
  assign coll_a = wstb_b & (word_b_wr == word_a);
  assign coll_b = wstb_a & (word_a == word_b_rd);
  assign rden_a = can_rd_a & (req_a_q.re | req_a_q.we) & ok_a; // [RULE3]
  assign rden_b = can_rd_b & req_b_rd.re & ok_b_rd;

  always_comb begin
    rd_a = (arr_a >> (int'(req_a_q.lane) * width_of(wcode_a))) & low_mask(wcode_a); // [RULE15]
    if (!ok_a) begin
      rd_a = '0;
    end else if (coll_a && !rdw_old) begin
      rd_a = UNKNOWN_FILL;
    end
  end

  always_comb begin
    rd_b = (arr_b >> (int'(req_b_rd.lane) * width_of(wcode_b))) & low_mask(wcode_b); // [RULE15]
    if (!ok_b_rd) begin
      rd_b = '0;
    end else if (coll_b && !rdw_old) begin
      rd_b = UNKNOWN_FILL; // [RULE2]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg_a <= '0;
    end else if (ce) begin
      if (clr_a) begin
        q_reg_a <= '0; // [RULE12]
      end else if (rden_a) begin
        q_reg_a <= rd_a; // [RULE5]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg_b <= '0;
    end else if (ce) begin
      if (clr_b) begin
        q_reg_b <= '0; // [RULE12]
      end else if (rden_b) begin
        q_reg_b <= rd_b; // [RULE2]
      end
    end
  end

  assign q_a = oreg_a ? q_reg_a : rd_a; // [RULE6]
  assign q_b = (oreg_b && !flow_on) ? q_reg_b : rd_b; // [RULE6] [RULE7]

  // ==========================================================
  // Sticky status, write one to clear, set wins
  logic [2:0] st_set;
  logic [2:0] st_clr;

  assign st_set[ST_COLL] = coll_a | coll_b;
  assign st_set[ST_LANE_A] = ce & (req_a_q.we | req_a_q.re) & ~ok_a;
  assign st_set[ST_LANE_B] = ce & (req_b_q.we | req_b_rd.re) & ~(ok_b_wr & ok_b_rd);
  assign st_clr = (apb_acc && pwrite && hit_status) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= 3'h0;
    end else if (ce) begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_dual_port_writes: assert property ( // [RULE1]
    (ce && mode == MODE_TRUE_DUAL && kind != KIND_SMALL && req_a_q.we && req_b_q.we
     && ok_a && ok_b_wr) |-> (wstb_a && wstb_b))
    else $error("both ports did not write together");

  a_rdw_fill_bits: assert property ( // [RULE2]
    (coll_b && !rdw_old && ok_b_rd) |-> (rd_b == UNKNOWN_FILL))
    else $error("read during write did not return fill bits");

  a_single_write_shows: assert property ( // [RULE3]
    (mode == MODE_SINGLE && !oreg_a && wstb_a && wcode_a == WCODE_36 && wbe_a == 4'hf)
    ##1 (req_a_q.addr == $past(req_a_q.addr) && req_a_q.lane == 6'h00)
    |-> (q_a == $past(req_a_q.data)))
    else $error("single port write not visible after the write edge");

  a_strobe_from_input: assert property ( // [RULE4]
    (ce && !rst && !clr_in_a && req_a.we && mode != MODE_ROM) ##1 (ok_a && ce) |-> wstb_a)
    else $error("captured write did not raise the strobe");

  a_input_captured: assert property ( // [RULE5]
    (ce && !clr_in_b) |=> (req_b_q == $past(req_b)))
    else $error("input register did not capture port b");

  a_oreg_pipeline: assert property ( // [RULE6]
    (ce && oreg_a && !clr_a && rden_a) |=> (q_a == $past(rd_a)))
    else $error("registered output did not follow read data");

  a_flow_uses_neg: assert property ( // [RULE7]
    flow_on |-> (q_b == rd_b && req_b_rd == req_b_n))
    else $error("flow-through read not taken from falling edge");

  a_split_halves: assert property ( // [RULE9]
    split |-> (!word_a[ADDR_W-1] && word_b_rd[ADDR_W-1] && word_b_wr[ADDR_W-1]))
    else $error("split memories overlap");

  a_byte_mask: assert property ( // [RULE11]
    wstb_b |-> ((wmask_b & ~be_mask(wbe_b)) == '0))
    else $error("masked byte lanes were written");

  a_large_clear: assert property ( // [RULE12]
    (ce && clr_b && kind == KIND_LARGE) |=> (q_reg_b == '0 && req_b_q == $past(req_b)))
    else $error("large block clear scope wrong");

endmodule : ramb_top

`default_nettype wire

// >>> verification/ramb_user.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Fabric-side user logic driving both memory ports
module ramb_user (
  input wire logic clk,
  output var ramb_pkg::ramb_req_t req_a,
  output var ramb_pkg::ramb_req_t req_b,
  output logic clr_a,
  output logic clr_b
);
  import ramb_pkg::*;

  initial begin
    req_a = '0;
    req_b = '0;
    clr_a = 1'b0;
    clr_b = 1'b0;
  end

  // Released lines show inverted stale fields so nothing passes by luck
  function automatic ramb_req_t idle(input ramb_req_t r);
    ramb_req_t t;
    t = ~r;
    t.we = 1'b0;
    t.re = 1'b0;
    return t;
  endfunction : idle

  // One request per port, held for one capture edge
  task automatic pair(input ramb_req_t ra, input ramb_req_t rb);
    @(posedge clk);
    req_a <= ra;
    req_b <= rb;
    @(posedge clk);
    req_a <= idle(ra);
    req_b <= idle(rb);
  endtask : pair

  // Port b request held until the caller changes it
  task automatic drive_b(input ramb_req_t r);
    req_b <= r;
  endtask : drive_b

  task automatic clear_a();
    @(posedge clk);
    clr_a <= 1'b1;
    @(posedge clk);
    clr_a <= 1'b0;
  endtask : clear_a

endmodule : ramb_user

`default_nettype wire

// >>> verification/embedded_ram_block_bench.sv
`timescale 1ns/1ps
`default_nettype none

module embedded_ram_block_bench;
  import ramb_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ramb_req_t req_a;
  ramb_req_t req_b;
  logic clr_a;
  logic clr_b;
  logic [35:0] q_a;
  logic [35:0] q_b;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic er;
  localparam logic [35:0] D1 = 36'hfedcba987;
  localparam logic [35:0] D3 = 36'h123456789;
  localparam logic [35:0] M5 = 36'h007fc01ff;

  always #4 clk = ~clk;

  ramb_user u_user (.clk(clk), .req_a(req_a), .req_b(req_b), .clr_a(clr_a), .clr_b(clr_b));

  ramb_top DUT (.clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_a(req_a), .clr_a(clr_a), .q_a(q_a),
    .req_b(req_b), .clr_b(clr_b), .q_b(q_b));

  // ==========================================================
  // Access helpers
  function automatic ramb_req_t mk(input logic w, input logic r, input logic [6:0] a,
      input logic [5:0] l, input logic [35:0] d, input logic [3:0] b);
    ramb_req_t t;
    t.we = w;
    t.re = r;
    t.addr = a;
    t.lane = l;
    t.data = d;
    t.be = b;
    return t;
  endfunction : mk

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ctrl(input logic [31:0] v);
    apb(1'b1, CTRL_OFF, v);
  endtask : ctrl

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CTRL_OFF, 32'h0);
    chk({4'h0, rd}, 36'h000005b68);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({4'h0, rd}, 36'h0);
    apb(1'b1, 12'h010, 32'h0000ffff);
    chk({35'h0, er}, 36'h1);
    apb(1'b1, CTRL_OFF, 32'hffff5b68);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk({4'h0, rd}, 36'h000005b68);
    done("registers");
    u_user.pair(mk(1, 0, 5, 0, D1, 4'hf), mk(1, 0, 6, 0, D3, 4'hf));
    u_user.pair(mk(0, 1, 6, 0, 0, 4'hf), mk(0, 1, 5, 0, 0, 4'hf));
    @(posedge clk);
    #1;
    chk(q_a, D3);
    chk(q_b, D1);
    u_user.pair(mk(1, 0, 5, 0, D3, 4'b0101), mk(0, 0, 0, 0, 0, 4'h0));
    u_user.pair(mk(0, 0, 0, 0, 0, 4'h0), mk(0, 1, 5, 0, 0, 4'hf));
    @(posedge clk);
    #1;
    chk(q_b, (D3 & M5) | (D1 & ~M5));
    chk(q_b[26:18], D3[26:18]);
    done("true_dual");
    ctrl(32'h00005768);
    u_user.pair(mk(0, 0, 0, 0, 0, 4'h0), mk(1, 0, 7, 0, 36'h0, 4'hf));
    u_user.pair(mk(1, 0, 7, 2, 36'h1a5, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    u_user.pair(mk(0, 0, 0, 0, 0, 4'h0), mk(0, 1, 7, 0, 0, 4'hf));
    @(posedge clk);
    #1;
    chk(q_b, 36'h006940000);
    chk(q_b[26:18], 9'h1a5);
    u_user.pair(mk(1, 0, 7, 4, 36'h1ff, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({4'h0, rd}, 36'h2);
    apb(1'b1, STATUS_OFF, 32'h00000002);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({4'h0, rd}, 36'h0);
    done("mixed_width");
    ctrl(32'h00005b0a);
    u_user.pair(mk(1, 0, 10, 0, D1, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    u_user.pair(mk(0, 1, 10, 0, 0, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    #1;
    chk(q_a, D1);
    ctrl(32'h00005b6a);
    u_user.pair(mk(1, 0, 11, 0, D3, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    u_user.pair(mk(0, 1, 11, 0, 0, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    @(posedge clk);
    #1;
    chk(q_a, D3);
    u_user.clear_a();
    #1;
    chk(q_a, 36'h0);
    // Clock enable low must keep a write presented meanwhile from ever being captured
    @(posedge clk);
    ce <= 1'b0;
    u_user.pair(mk(1, 0, 11, 0, D1, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    @(posedge clk);
    ce <= 1'b1;
    u_user.pair(mk(0, 1, 11, 0, 0, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    @(posedge clk);
    #1;
    chk(q_a, D3);
    done("single_port");
    ctrl(32'h00005b09);
    u_user.pair(mk(1, 0, 12, 0, D1, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    u_user.pair(mk(1, 0, 12, 0, D3, 4'hf), mk(0, 1, 12, 0, 0, 4'hf));
    #1;
    chk(q_b, D1);
    ctrl(32'h00005a09);
    u_user.pair(mk(1, 0, 12, 0, D1, 4'hf), mk(0, 1, 12, 0, 0, 4'hf));
    #1;
    chk(q_b, UNKNOWN_FILL);
    ctrl(32'h00005b89);
    @(posedge clk);
    u_user.drive_b(mk(0, 1, 12, 0, 0, 4'hf));
    @(negedge clk);
    #1;
    chk(q_b, D1);
    @(posedge clk);
    u_user.drive_b(mk(0, 0, 12, 0, 0, 4'hf));
    done("simple_dual");
    ctrl(32'h00005b6b);
    u_user.pair(mk(1, 0, 3, 0, D1, 4'hf), mk(1, 0, 3, 0, D3, 4'hf));
    u_user.pair(mk(0, 1, 3, 0, 0, 4'hf), mk(0, 1, 3, 0, 0, 4'hf));
    @(posedge clk);
    #1;
    chk(q_a, D1);
    chk(q_b, D3);
    ctrl(32'h00005b6c);
    u_user.pair(mk(1, 0, 3, 0, D3, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    u_user.pair(mk(0, 1, 3, 0, 0, 4'hf), mk(0, 0, 0, 0, 0, 4'h0));
    @(posedge clk);
    #1;
    chk(q_a, D1);
    done("split_rom");
    complete_run();
  end

endmodule : embedded_ram_block_bench

`default_nettype wire
